// ===== hw/fpl_lamp_driver.sv
`timescale 1ns/1ps
module fpl_lamp_driver #(
   parameter int unsigned LAMP_TEST_CYC  = fpl_pkg::LAMP_TEST_CYC,   // lamp test length
   parameter int unsigned BLINK_HALF_CYC = fpl_pkg::BLINK_HALF_CYC,  // blink half period
   parameter int unsigned FLASH_CYC      = fpl_pkg::FLASH_CYC        // fault flash length
) (
   input  wire logic ref_clk_i,          // system clock, 100 MHz
   input  wire logic reset_n_i,          // async reset, active low
   input  wire logic loader_enter_i,     // start phase finished, loader console running
   input  wire logic normal_enter_i,     // loader finished, normal operation
   input  wire logic mem_test_run_i,     // memory self-test running
   input  wire logic isdn_test_run_i,    // ISDN self-test running
   input  wire logic lan_test_run_i,     // LAN self-test running
   input  wire logic mem_test_fail_i,    // memory self-test failed
   input  wire logic isdn_test_fail_i,   // ISDN self-test failed
   input  wire logic lan_test_fail_i,    // LAN self-test failed
   input  wire logic ldr_active_i,       // loader active or awaiting keyboard
   input  wire logic ldr_compress_i,     // loader compressing system software
   input  wire logic ldr_fdr_ready_i,    // ready for factory-default reset
   input  wire logic ldr_fdr_done_i,     // pulse: factory-default reset succeeded
   input  wire logic ldr_last_err_i,     // last loader action had an error
   input  wire logic lan_link_up_i,      // LAN layer 1 link up
   input  wire logic lan_packet_i,       // packets passing LAN interface
   input  wire logic isdn_link_up_i,     // ISDN layer 1 link up
   input  wire logic isdn_b1_i,          // one B-channel active
   input  wire logic isdn_b2_i,          // two B-channels active
   input  wire logic shdsl_conn_i,       // SHDSL connection established
   input  wire logic shdsl_traffic_i,    // SHDSL carrying traffic
   input  wire logic lan_err_i,          // pulse: LAN error or collision
   input  wire logic sys_restart_i,      // system stopped, restart in progress
   output logic      supply_lamp_o,      // supply lamp
   output logic      fault_lamp_o,       // fault lamp
   output logic      shdsl_green_o,      // SHDSL green element
   output logic      shdsl_orange_o,     // SHDSL orange element
   output logic      isdn_green_o,       // ISDN green element
   output logic      isdn_orange_o,      // ISDN orange element
   output logic      lan_link_lamp_o,    // LAN link lamp
   output logic      lan_traffic_lamp_o, // LAN traffic lamp
   output logic [2:0] phase_o            // current operating phase
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   fpl_pkg::fpl_phase_t       phase_q;
   fpl_pkg::fpl_phase_t       phase_d;
   logic [fpl_pkg::CNT_W-1:0] test_cnt_q;
   logic [2:0]                fdr_left_q;   // blink half-periods remaining, counted in full blinks x2
   logic                      fdr_on_q;
   logic                      blink;
   logic                      blink_edge;
   logic                      err_flash;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   fpl_blink_gen #(
      .HALF_CYC (BLINK_HALF_CYC)
   ) u_blink (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .blink_o   (blink),
      .toggle_o  (blink_edge)
   );

   fpl_pulse_stretch #(
      .LEN_CYC (FLASH_CYC)
   ) u_flash (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .event_i   (lan_err_i),
      .flash_o   (err_flash)
   );

   // ------------------------------------------------------------
   // phase sequencing
   // ------------------------------------------------------------
   wire test_done = (test_cnt_q == fpl_pkg::CNT_W'(LAMP_TEST_CYC - 1));

   always_comb begin
      phase_d = phase_q;
      unique case (phase_q)
         fpl_pkg::FPL_LAMP_TEST: if (test_done) phase_d = fpl_pkg::FPL_START;
         fpl_pkg::FPL_START:     if (loader_enter_i) phase_d = fpl_pkg::FPL_LOADER;
         fpl_pkg::FPL_LOADER:    if (normal_enter_i) phase_d = fpl_pkg::FPL_NORMAL;
         fpl_pkg::FPL_NORMAL:    phase_d = phase_q;
         default:                phase_d = fpl_pkg::FPL_LAMP_TEST;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         phase_q    <= fpl_pkg::FPL_LAMP_TEST;
         test_cnt_q <= '0;
      end else begin
         phase_q    <= phase_d;
         test_cnt_q <= (phase_q == fpl_pkg::FPL_LAMP_TEST) ? test_cnt_q + 1'b1 : '0;
      end
   end

   // ------------------------------------------------------------
   // factory reset blink sequence: three on/off blinks on the blink clock
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fdr_left_q <= '0;
         fdr_on_q   <= 1'b0;
      end else if (ldr_fdr_done_i && phase_q == fpl_pkg::FPL_LOADER) begin
         fdr_left_q <= 3'(2 * fpl_pkg::FACTORY_BLINKS);
         fdr_on_q   <= 1'b0;
      end else if (blink_edge && fdr_left_q != '0) begin
         fdr_left_q <= fdr_left_q - 1'b1;
         fdr_on_q   <= ~fdr_on_q;
      end
   end

   wire fdr_blinking = (fdr_left_q != '0);

   // ------------------------------------------------------------
   // start phase decode
   // ------------------------------------------------------------
   wire any_fail  = mem_test_fail_i | isdn_test_fail_i | lan_test_fail_i;
   wire st_fault  = (mem_test_fail_i & mem_test_run_i) | (isdn_test_fail_i & isdn_test_run_i)
                  | (lan_test_fail_i & lan_test_run_i) | any_fail;
   wire st_igreen = mem_test_run_i | mem_test_fail_i;
   wire st_iorng  = isdn_test_run_i | isdn_test_fail_i;
   wire st_traf   = lan_test_run_i | lan_test_fail_i;

   // ------------------------------------------------------------
   // loader phase decode
   // ------------------------------------------------------------
   wire ld_group  = fdr_blinking ? fdr_on_q : ldr_fdr_ready_i;
   wire ld_isdn   = ld_group | (ldr_compress_i ? blink : ldr_active_i);
   wire ld_shdsl  = ld_group;
   wire ld_link   = fdr_blinking ? fdr_on_q : (ldr_fdr_ready_i | lan_link_up_i);
   wire ld_traf   = fdr_blinking ? fdr_on_q : (ldr_fdr_ready_i | lan_packet_i);
   wire ld_fault  = ldr_last_err_i;

   // ------------------------------------------------------------
   // normal phase decode
   // ------------------------------------------------------------
   wire nm_sgreen = shdsl_conn_i;
   wire nm_sorng  = shdsl_traffic_i & blink;
   wire nm_igreen = isdn_link_up_i;
   wire nm_iorng  = isdn_b2_i ? blink : isdn_b1_i;
   wire nm_link   = lan_link_up_i;
   wire nm_traf   = lan_packet_i & blink;
   wire nm_fault  = sys_restart_i | err_flash;

   // ------------------------------------------------------------
   // phase select
   // ------------------------------------------------------------
   wire in_test   = (phase_q == fpl_pkg::FPL_LAMP_TEST);
   wire in_start  = (phase_q == fpl_pkg::FPL_START);
   wire in_loader = (phase_q == fpl_pkg::FPL_LOADER);
   wire in_normal = (phase_q == fpl_pkg::FPL_NORMAL);

   wire fault_d   = in_test | (in_start & st_fault) | (in_loader & ld_fault) | (in_normal & nm_fault);
   wire sgreen_d  = in_test | (in_loader & ld_shdsl) | (in_normal & nm_sgreen);
   wire sorng_d   = in_test | (in_loader & ld_shdsl) | (in_normal & nm_sorng);
   wire igreen_d  = in_test | (in_start & st_igreen) | (in_loader & ld_isdn) | (in_normal & nm_igreen);
   wire iorng_d   = in_test | (in_start & st_iorng) | (in_loader & ld_isdn) | (in_normal & nm_iorng);
   wire link_d    = in_test | (in_loader & ld_link) | (in_normal & nm_link);
   wire traf_d    = in_test | (in_start & st_traf) | (in_loader & ld_traf) | (in_normal & nm_traf);

   // ------------------------------------------------------------
   // registered lamp outputs
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         supply_lamp_o      <= 1'b0;
         fault_lamp_o       <= 1'b0;
         shdsl_green_o      <= 1'b0;
         shdsl_orange_o     <= 1'b0;
         isdn_green_o       <= 1'b0;
         isdn_orange_o      <= 1'b0;
         lan_link_lamp_o    <= 1'b0;
         lan_traffic_lamp_o <= 1'b0;
         phase_o            <= '0;
      end else begin
         supply_lamp_o      <= 1'b1;
         fault_lamp_o       <= fault_d;
         shdsl_green_o      <= sgreen_d;
         shdsl_orange_o     <= sorng_d;
         isdn_green_o       <= igreen_d;
         isdn_orange_o      <= iorng_d;
         lan_link_lamp_o    <= link_d;
         lan_traffic_lamp_o <= traf_d;
         phase_o            <= phase_q;
      end
   end
endmodule

// ===== hw/fpl_pkg.sv
package fpl_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 10;                          // ref_clk_i period
   localparam int unsigned LAMP_TEST_MS   = 500;                         // lamp test length
   localparam int unsigned LAMP_TEST_CYC  = LAMP_TEST_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned BLINK_HALF_CYC = 25000000;                    // 250 ms per blink half period
   localparam int unsigned FLASH_CYC      = 5000000;                     // 50 ms fault flash
   localparam int unsigned FACTORY_BLINKS = 3;                           // factory reset blink count
   localparam int unsigned CNT_W          = 32;                          // timer width

   // ------------------------------------------------------------
   // operating phases
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      FPL_LAMP_TEST,
      FPL_START,
      FPL_LOADER,
      FPL_NORMAL
   } fpl_phase_t;
endpackage

// ===== hw/fpl_blink_gen.sv
`timescale 1ns/1ps
// free-running square wave used for every blinking lamp
module fpl_blink_gen #(
   parameter int unsigned HALF_CYC = fpl_pkg::BLINK_HALF_CYC  // cycles per half period
) (
   input  wire logic ref_clk_i,    // system clock
   input  wire logic reset_n_i,    // async reset, active low
   output logic      blink_o,      // square wave
   output logic      toggle_o      // one-cycle pulse at each edge of blink_o
);
   logic [fpl_pkg::CNT_W-1:0] cnt_q;
   wire                       wrap = (cnt_q == fpl_pkg::CNT_W'(HALF_CYC - 1));

   // ------------------------------------------------------------
   // half-period counter
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_q    <= '0;
         blink_o  <= 1'b0;
         toggle_o <= 1'b0;
      end else begin
         cnt_q    <= wrap ? '0 : cnt_q + 1'b1;
         blink_o  <= wrap ? ~blink_o : blink_o;
         toggle_o <= wrap;
      end
   end
endmodule

// ===== hw/fpl_pulse_stretch.sv
`timescale 1ns/1ps
// stretches each event pulse into a visible flash
module fpl_pulse_stretch #(
   parameter int unsigned LEN_CYC = fpl_pkg::FLASH_CYC  // flash length in cycles
) (
   input  wire logic ref_clk_i,    // system clock
   input  wire logic reset_n_i,    // async reset, active low
   input  wire logic event_i,      // event pulse
   output logic      flash_o       // stretched flash
);
   logic [fpl_pkg::CNT_W-1:0] cnt_q;

   // ------------------------------------------------------------
   // retrigger on each event
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_q   <= '0;
         flash_o <= 1'b0;
      end else begin
         if (event_i) begin
            cnt_q <= fpl_pkg::CNT_W'(LEN_CYC);
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
         end
         flash_o <= event_i || (cnt_q > fpl_pkg::CNT_W'(1));
      end
   end
endmodule

// ===== test/fpl_lamp_panel.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// lamp panel model: counts lightings of the four-lamp group
// ------------------------------------------------------------
module fpl_lamp_panel (
   input  wire logic       ref_clk_i,   // system clock
   input  wire logic       reset_n_i,   // async reset, active low
   input  wire logic [7:0] lamps_i,     // lamp states, supply first
   output logic      [7:0] group_cnt_o  // group lightings seen
);
   // a line lamp is yellow only with both elements lit
   wire group_on = (&lamps_i[5:2]) & lamps_i[1] & lamps_i[0];
   logic group_q;
   // count each dark-to-lit step of the whole group
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         group_q     <= 1'h0;
         group_cnt_o <= 8'h00;
      end else begin
         group_q <= group_on;
         if (group_on && !group_q) group_cnt_o <= group_cnt_o + 8'h01;
      end
   end
endmodule

// ===== test/fpl_lamp_driver_asserts.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module fpl_lamp_driver_chk (
   input wire logic       ref_clk_i,          // clock
   input wire logic       reset_n_i,          // reset, active low
   input wire logic       mem_test_run_i,     // memory test
   input wire logic       mem_test_fail_i,    // memory fail
   input wire logic       lan_test_fail_i,    // lan fail
   input wire logic       ldr_active_i,       // loader active
   input wire logic       ldr_compress_i,     // loader compress
   input wire logic       lan_err_i,          // lan error pulse
   input wire logic       sys_restart_i,      // restart
   input wire logic       supply_lamp_o,      // supply lamp
   input wire logic       fault_lamp_o,       // fault lamp
   input wire logic       shdsl_green_o,      // shdsl green
   input wire logic       shdsl_orange_o,     // shdsl orange
   input wire logic       isdn_green_o,       // isdn green
   input wire logic       isdn_orange_o,      // isdn orange
   input wire logic       lan_link_lamp_o,    // link lamp
   input wire logic       lan_traffic_lamp_o, // traffic lamp
   input wire logic [2:0] phase_o             // phase
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   // phase decode and lamp-test pattern
   wire all_on = supply_lamp_o & fault_lamp_o & shdsl_green_o & shdsl_orange_o & isdn_green_o & isdn_orange_o
                 & lan_link_lamp_o & lan_traffic_lamp_o;
   wire in_st  = phase_o == 3'h1;
   lamp_test_a: assert property ($rose(reset_n_i) |-> ##2 all_on [*8])
      else $error("lamp test not all on");
   phase_order_a: assert property (phase_o != $past(phase_o) |-> phase_o == $past(phase_o) + 3'h1)
      else $error("phase out of order");
   start_dark_a: assert property (in_st && $past(phase_o, 2) == 3'h1
      |-> !(shdsl_green_o | shdsl_orange_o | lan_link_lamp_o))
      else $error("start phase lamp lit");
   mem_lamp_a: assert property (in_st && $past(in_st) && $rose(mem_test_run_i) |-> ##[1:2] isdn_green_o)
      else $error("memory test lamp dark");
   test_end_a: assert property (in_st && $fell(mem_test_run_i) && !mem_test_fail_i |-> ##[1:2] !isdn_green_o)
      else $error("test lamp stays lit");
   fail_fault_a: assert property (in_st && $rose(lan_test_fail_i)
      |-> ##[1:2] (fault_lamp_o && lan_traffic_lamp_o))
      else $error("fail not shown");
   loader_yellow_a: assert property ((phase_o == 3'h2 && ldr_active_i && !ldr_compress_i) [*3]
      |-> isdn_green_o && isdn_orange_o)
      else $error("loader not yellow");
   err_flash_a: assert property (phase_o == 3'h3 && $rose(lan_err_i) |-> ##[1:2] fault_lamp_o)
      else $error("no fault flash");
   restart_fault_a: assert property ((phase_o == 3'h3 && sys_restart_i) [*3] |-> fault_lamp_o)
      else $error("restart fault dark");
endmodule
bind fpl_lamp_driver fpl_lamp_driver_chk u_fpl_lamp_driver_chk (
   .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .mem_test_run_i(mem_test_run_i), .mem_test_fail_i(mem_test_fail_i),
   .lan_test_fail_i(lan_test_fail_i), .ldr_active_i(ldr_active_i), .ldr_compress_i(ldr_compress_i),
   .lan_err_i(lan_err_i), .sys_restart_i(sys_restart_i), .supply_lamp_o(supply_lamp_o), .fault_lamp_o(fault_lamp_o),
   .shdsl_green_o(shdsl_green_o), .shdsl_orange_o(shdsl_orange_o), .isdn_green_o(isdn_green_o),
   .isdn_orange_o(isdn_orange_o), .lan_link_lamp_o(lan_link_lamp_o), .lan_traffic_lamp_o(lan_traffic_lamp_o),
   .phase_o(phase_o));

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   // ------------------------------------------------------------
   // signals and instances
   // ------------------------------------------------------------
   logic ref_clk_i, reset_n_i, loader_enter_i, normal_enter_i, mem_test_run_i, isdn_test_run_i, lan_test_run_i;
   logic mem_test_fail_i, isdn_test_fail_i, lan_test_fail_i, ldr_active_i, ldr_compress_i, ldr_fdr_ready_i;
   logic ldr_fdr_done_i, ldr_last_err_i, lan_link_up_i, lan_packet_i, isdn_link_up_i, isdn_b1_i, isdn_b2_i;
   logic shdsl_conn_i, shdsl_traffic_i, lan_err_i, sys_restart_i, supply_lamp_o, fault_lamp_o, shdsl_green_o;
   logic shdsl_orange_o, isdn_green_o, isdn_orange_o, lan_link_lamp_o, lan_traffic_lamp_o;
   logic [2:0] phase_o;
   logic [7:0] group_cnt, cnt0;
   int         n_mismatch = 0, n_checks = 0;
   wire  [7:0] lamps = {supply_lamp_o, fault_lamp_o, shdsl_green_o, shdsl_orange_o, isdn_green_o, isdn_orange_o,
                        lan_link_lamp_o, lan_traffic_lamp_o};
   fpl_lamp_driver #(.LAMP_TEST_CYC(20), .BLINK_HALF_CYC(4), .FLASH_CYC(3)) u_fpl_lamp_driver (
      .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .loader_enter_i(loader_enter_i), .normal_enter_i(normal_enter_i),
      .mem_test_run_i(mem_test_run_i), .isdn_test_run_i(isdn_test_run_i), .lan_test_run_i(lan_test_run_i),
      .mem_test_fail_i(mem_test_fail_i), .isdn_test_fail_i(isdn_test_fail_i), .lan_test_fail_i(lan_test_fail_i),
      .ldr_active_i(ldr_active_i), .ldr_compress_i(ldr_compress_i), .ldr_fdr_ready_i(ldr_fdr_ready_i),
      .ldr_fdr_done_i(ldr_fdr_done_i), .ldr_last_err_i(ldr_last_err_i), .lan_link_up_i(lan_link_up_i),
      .lan_packet_i(lan_packet_i), .isdn_link_up_i(isdn_link_up_i), .isdn_b1_i(isdn_b1_i), .isdn_b2_i(isdn_b2_i),
      .shdsl_conn_i(shdsl_conn_i), .shdsl_traffic_i(shdsl_traffic_i), .lan_err_i(lan_err_i),
      .sys_restart_i(sys_restart_i), .supply_lamp_o(supply_lamp_o), .fault_lamp_o(fault_lamp_o),
      .shdsl_green_o(shdsl_green_o), .shdsl_orange_o(shdsl_orange_o), .isdn_green_o(isdn_green_o),
      .isdn_orange_o(isdn_orange_o), .lan_link_lamp_o(lan_link_lamp_o), .lan_traffic_lamp_o(lan_traffic_lamp_o),
      .phase_o(phase_o));
   fpl_lamp_panel u_fpl_lamp_panel (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .lamps_i(lamps),
                                    .group_cnt_o(group_cnt));
   // clock, 100 MHz
   initial begin
      ref_clk_i = 1'h0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   task automatic pulse(ref logic s);
      s = 1'h1;
      cyc(1);
      s = 1'h0;
   endtask
   task automatic clr;
      {loader_enter_i, normal_enter_i, mem_test_run_i, isdn_test_run_i, lan_test_run_i, mem_test_fail_i} = '0;
      {isdn_test_fail_i, lan_test_fail_i, ldr_active_i, ldr_compress_i, ldr_fdr_ready_i, ldr_fdr_done_i} = '0;
      {ldr_last_err_i, lan_link_up_i, lan_packet_i, isdn_link_up_i, isdn_b1_i, isdn_b2_i, shdsl_conn_i} = '0;
      {shdsl_traffic_i, lan_err_i, sys_restart_i} = '0;
   endtask
   // steady lamps lit in every sample, blinking ones seen both ways
   task automatic look(input logic [7:0] on, input logic [7:0] blk, input int settle);
      logic [7:0] a, o;
      cyc(settle);
      a = 8'hff;
      o = 8'h00;
      repeat (12) begin
         @(negedge ref_clk_i);
         a = a & lamps;
         o = o | lamps;
      end
      chk(a, on);
      chk(o, on | blk);
   endtask
   task automatic wph(input logic [2:0] p);
      for (int i = 0; i < 60 && phase_o !== p; i++) cyc(1);
      chk({5'h00, phase_o}, {5'h00, p});
      if (phase_o !== p) summarize();
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_lamp_test;
      reset_n_i = 1'h0;
      cyc(8);
      reset_n_i = 1'h1;
      look(8'hff, 8'h00, 2);
      wph(3'h1);
   endtask
   task automatic t_start;
      logic [7:0] bits [3] = '{8'h08, 8'h04, 8'h01};
      lan_link_up_i = 1'h1;
      pulse(normal_enter_i);
      look(8'h80, 8'h00, 3);
      chk({5'h00, phase_o}, 8'h01);
      for (int i = 0; i < 3; i++) begin
         {mem_test_run_i, isdn_test_run_i, lan_test_run_i} = 3'h4 >> i;
         look(8'h80 | bits[i], 8'h00, 3);
         {mem_test_fail_i, isdn_test_fail_i, lan_test_fail_i} = 3'h4 >> i;
         look(8'hc0 | bits[i], 8'h00, 3);
         {mem_test_run_i, isdn_test_run_i, lan_test_run_i, mem_test_fail_i, isdn_test_fail_i, lan_test_fail_i} = '0;
         look(8'h80, 8'h00, 3);
      end
      pulse(loader_enter_i);
      wph(3'h2);
   endtask
   task automatic t_loader;
      ldr_active_i = 1'h1;
      look(8'h8e, 8'h00, 3);
      ldr_compress_i = 1'h1;
      look(8'h82, 8'h0c, 3);
      {ldr_active_i, ldr_compress_i, ldr_fdr_ready_i, ldr_last_err_i} = 4'h3;
      look(8'hff, 8'h00, 3);
      {ldr_fdr_ready_i, ldr_last_err_i} = 2'h0;
      cnt0 = group_cnt;
      pulse(ldr_fdr_done_i);
      cyc(40);
      chk(group_cnt - cnt0, 8'h03);
      lan_packet_i = 1'h1;
      look(8'h83, 8'h00, 3);
      pulse(normal_enter_i);
      wph(3'h3);
   endtask
   task automatic t_normal;
      {shdsl_conn_i, shdsl_traffic_i, isdn_link_up_i, isdn_b1_i, lan_packet_i} = 5'h1e;
      look(8'hae, 8'h10, 3);
      {isdn_b1_i, isdn_b2_i, lan_packet_i} = 3'h3;
      look(8'haa, 8'h15, 3);
      clr();
      pulse(lan_err_i);
      look(8'h80, 8'h40, 0);
      pulse(loader_enter_i);
      chk({5'h00, phase_o}, 8'h03);
      sys_restart_i = 1'h1;
      look(8'hc0, 8'h00, 3);
      clr();
   endtask
   // main sequence, ending with a reset in mid-run
   initial begin
      reset_n_i = 1'h0;
      clr();
      t_lamp_test();
      t_start();
      t_loader();
      t_normal();
      t_lamp_test();
      summarize();
   end
endmodule
